// ==== logic/cwu_top.sv ====
// Core of the complementary waveform unit with its register file.
`timescale 1ns/10ps
`default_nettype none
`include "cwu_params.svh"
module cwu_top #(
  parameter int SRC_N = 12,
  parameter int FAULT_N = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire cwu_pkg::cwu_word_t haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire cwu_pkg::cwu_word_t hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [SRC_N-1:0] data_src_i,
  input wire logic [SRC_N-1:0] src_active_i,
  input wire logic [FAULT_N-1:0] fault_n_i,
  input wire logic fast_osc_i,
  output logic [3:0] wave_o,
  output logic [3:0] wave_oe_o,
  output logic fast_osc_keep_o
);
  import cwu_pkg::*;

  cwu_reg_if regs();
  cwu_db_if db_rise();
  cwu_db_if db_fall();

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SRC_N-1:0] src_s1_reg, src_s2_reg, act_s1_reg, act_s2_reg;
  logic [FAULT_N-1:0] flt_s1_reg, flt_s2_reg;
  logic [2:0] osc_sh_reg;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
      act_s1_reg <= '0;
      act_s2_reg <= '0;
      flt_s1_reg <= '1;
      flt_s2_reg <= '1;
      osc_sh_reg <= 3'h0;
    end else begin
      src_s1_reg <= data_src_i;
      src_s2_reg <= src_s1_reg;
      act_s1_reg <= src_active_i;
      act_s2_reg <= act_s1_reg;
      flt_s1_reg <= fault_n_i;
      flt_s2_reg <= flt_s1_reg;
      osc_sh_reg <= {osc_sh_reg[1:0], fast_osc_i};
    end
  end

  // ----------------------------------------
  // Registers and control state
  // ----------------------------------------
  logic cs_reg, cs_next;
  logic [3:0] ism_reg, ism_next;
  logic [5:0] dbr_reg, dbr_next, dbf_reg, dbf_next;
  logic [5:0] dbr_buf_reg, dbr_buf_next, dbf_buf_reg, dbf_buf_next;
  logic en_reg, en_next, ld_reg, ld_next, armed_reg, armed_next;
  cwu_mode_e mode_reg, mode_next;
  logic [3:0] pol_reg, pol_next;
  logic shut_reg, shut_next, ren_reg, ren_next, run_reg, run_next;
  logic [1:0] second_pair_safe_level_reg, second_pair_safe_level_next, first_pair_safe_level_reg, first_pair_safe_level_next;
  logic [7:0] ase_reg, ase_next, str_reg, str_next;
  logic [3:0] strb_reg, strb_next;
  logic din_q_reg, phase_reg, phase_next;
  logic data, rise, fall, fault, gen_tick, src_act;
  logic wr_clk, wr_ism, wr_dbr, wr_dbf, wr_con0, wr_con1, wr_as0, wr_as1, wr_str;

  always_comb begin
    // Reserved source codes feed a constant low.
    data = (ism_reg <= `CWU_ISM_LAST) ? src_s2_reg[ism_reg] : 1'b0;
    src_act = (ism_reg <= `CWU_ISM_LAST) ? act_s2_reg[ism_reg] : 1'b0;
    rise = data && !din_q_reg;
    fall = !data && din_q_reg;
    fault = |(~flt_s2_reg & ase_reg);
    gen_tick = cs_reg ? (osc_sh_reg[1] && !osc_sh_reg[2]) : 1'b1;
    wr_clk = regs.wr && regs.wr_idx == `CWU_IDX_CLK;
    wr_ism = regs.wr && regs.wr_idx == `CWU_IDX_ISM;
    wr_dbr = regs.wr && regs.wr_idx == `CWU_IDX_DBR;
    wr_dbf = regs.wr && regs.wr_idx == `CWU_IDX_DBF;
    wr_con0 = regs.wr && regs.wr_idx == `CWU_IDX_CON0;
    wr_con1 = regs.wr && regs.wr_idx == `CWU_IDX_CON1;
    wr_as0 = regs.wr && regs.wr_idx == `CWU_IDX_AS0;
    wr_as1 = regs.wr && regs.wr_idx == `CWU_IDX_AS1;
    wr_str = regs.wr && regs.wr_idx == `CWU_IDX_STR;

    cs_next = wr_clk ? regs.wdata[`CWU_CS_BIT] : cs_reg;
    ism_next = wr_ism ? regs.wdata[3:0] : ism_reg;
    dbr_next = wr_dbr ? regs.wdata[5:0] : dbr_reg;
    dbf_next = wr_dbf ? regs.wdata[5:0] : dbf_reg;
    en_next = wr_con0 ? regs.wdata[`CWU_EN_BIT] : en_reg;
    mode_next = wr_con0 ? cwu_mode_e'(regs.wdata[2:0]) : mode_reg;
    pol_next = wr_con1 ? regs.wdata[3:0] : pol_reg;
    ren_next = wr_as0 ? regs.wdata[`CWU_REN_BIT] : ren_reg;
    second_pair_safe_level_next = wr_as0 ? regs.wdata[5:4] : second_pair_safe_level_reg;
    first_pair_safe_level_next = wr_as0 ? regs.wdata[3:2] : first_pair_safe_level_reg;
    ase_next = wr_as1 ? regs.wdata : ase_reg;
    str_next = wr_str ? regs.wdata : str_reg;

    // Buffered dead-band counts follow the registers while disabled.
    dbr_buf_next = en_reg ? dbr_buf_reg : dbr_next;
    dbf_buf_next = en_reg ? dbf_buf_reg : dbf_next;
    ld_next = ld_reg;
    armed_next = armed_reg;
    if (ld_reg && fall) begin
      armed_next = 1'b1;
    end
    if (armed_reg && rise) begin
      dbr_buf_next = dbr_reg;
      dbf_buf_next = dbf_reg;
      ld_next = 1'b0;
      armed_next = 1'b0;
    end
    // A request in the write that turns enable on is dropped; a new one wins the clear.
    if (wr_con0 && regs.wdata[`CWU_LD_BIT] && en_reg) begin
      ld_next = 1'b1;
    end
    if (!en_next) begin
      ld_next = 1'b0;
      armed_next = 1'b0;
    end

    // Shutdown: any setting source wins over a clear in the same cycle.
    shut_next = shut_reg;
    if (wr_as0 && !regs.wdata[`CWU_SHUT_BIT] && !fault) begin
      shut_next = 1'b0;
    end
    if (ren_reg && !fault && en_reg) begin
      shut_next = 1'b0;
    end
    if (fault || (wr_as0 && regs.wdata[`CWU_SHUT_BIT]) || (en_next && !en_reg)) begin
      shut_next = 1'b1;
    end

    run_next = run_reg;
    if (shut_reg || !en_reg) begin
      run_next = 1'b0;
    end else if (rise) begin
      run_next = 1'b1;
    end
    strb_next = (mode_reg == CWU_SYNC_STEER && rise) ? str_reg[3:0] : strb_reg;
    phase_next = rise ? !phase_reg : phase_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cs_reg <= 1'b0;
      ism_reg <= 4'h0;
      dbr_reg <= `CWU_RST_DB;
      dbf_reg <= `CWU_RST_DB;
      dbr_buf_reg <= `CWU_RST_DB;
      dbf_buf_reg <= `CWU_RST_DB;
      en_reg <= 1'b0;
      ld_reg <= 1'b0;
      armed_reg <= 1'b0;
      mode_reg <= CWU_ASYNC_STEER;
      pol_reg <= 4'h0;
      shut_reg <= 1'b0;
      ren_reg <= 1'b0;
      run_reg <= 1'b0;
      second_pair_safe_level_reg <= 2'b00;
      first_pair_safe_level_reg <= 2'b00;
      ase_reg <= `CWU_RST_BYTE;
      str_reg <= `CWU_RST_BYTE;
      strb_reg <= 4'h0;
      din_q_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else begin
      cs_reg <= cs_next;
      ism_reg <= ism_next;
      dbr_reg <= dbr_next;
      dbf_reg <= dbf_next;
      dbr_buf_reg <= dbr_buf_next;
      dbf_buf_reg <= dbf_buf_next;
      en_reg <= en_next;
      ld_reg <= ld_next;
      armed_reg <= armed_next;
      mode_reg <= mode_next;
      pol_reg <= pol_next;
      shut_reg <= shut_next;
      ren_reg <= ren_next;
      run_reg <= run_next;
      second_pair_safe_level_reg <= second_pair_safe_level_next;
      first_pair_safe_level_reg <= first_pair_safe_level_next;
      ase_reg <= ase_next;
      str_reg <= str_next;
      strb_reg <= strb_next;
      din_q_reg <= data;
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    unique case (regs.rd_idx)
      `CWU_IDX_CLK: regs.rdata = {7'h00, cs_reg};
      `CWU_IDX_ISM: regs.rdata = {4'h0, ism_reg};
      `CWU_IDX_DBR: regs.rdata = {2'b00, dbr_reg};
      `CWU_IDX_DBF: regs.rdata = {2'b00, dbf_reg};
      `CWU_IDX_CON0: regs.rdata = {en_reg, ld_reg, 3'b000, mode_reg};
      `CWU_IDX_CON1: regs.rdata = {2'b00, data, 1'b0, pol_reg};
      `CWU_IDX_AS0: regs.rdata = {shut_reg, ren_reg, second_pair_safe_level_reg, first_pair_safe_level_reg, 2'b00};
      `CWU_IDX_AS1: regs.rdata = ase_reg;
      `CWU_IDX_STR: regs.rdata = str_reg;
      default: regs.rdata = `CWU_RST_BYTE;
    endcase
  end

  cwu_ahb_slave u_bus (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .regs(regs)
  );

  // ----------------------------------------
  // Dead band and output shaping
  // ----------------------------------------
  assign db_rise.tick = gen_tick;
  assign db_rise.din = data;
  assign db_rise.count = dbr_buf_reg;
  assign db_fall.tick = gen_tick;
  assign db_fall.din = !data;
  assign db_fall.count = dbf_buf_reg;

  cwu_deadband u_db_rise (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .db(db_rise)
  );
  cwu_deadband u_db_fall (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .db(db_fall)
  );

  logic [3:0] raw, wave_next, oe_next, wave_reg, oe_reg;
  logic [3:0] steer;
  logic keep_reg, keep_next;

  always_comb begin
    steer = (mode_reg == CWU_SYNC_STEER) ? strb_reg : str_reg[3:0];
    unique case (mode_reg)
      CWU_PUSH_PULL: raw = {2'b00, data && !phase_reg, data && phase_reg};
      CWU_HALF_BRIDGE: raw = {2'b00, db_fall.dout, db_rise.dout};
      CWU_FWD_BRIDGE: raw = {data && !db_fall.dout, 2'b00, 1'b1};
      CWU_REV_BRIDGE: raw = {1'b0, 1'b1, db_rise.dout, 1'b0};
      CWU_ASYNC_STEER, CWU_SYNC_STEER: raw = {4{data}};
      default: raw = 4'h0;
    endcase
    wave_next = raw ^ pol_reg;
    oe_next = 4'hf;
    if (mode_reg == CWU_ASYNC_STEER || mode_reg == CWU_SYNC_STEER) begin
      wave_next = (steer & ({4{data}} ^ pol_reg)) | (~steer & str_reg[7:4]);
    end
    if (!run_reg) begin
      // Inactive level including polarity unless a fixed level or release is chosen.
      wave_next = pol_reg;
      for (int i = 0; i < 4; i++) begin
        unique case (i[0] ? second_pair_safe_level_reg : first_pair_safe_level_reg)
          `CWU_LVL_HIGH: wave_next[i] = 1'b1;
          `CWU_LVL_LOW: wave_next[i] = 1'b0;
          `CWU_LVL_TRI: oe_next[i] = 1'b0;
          default: wave_next[i] = pol_reg[i];
        endcase
      end
    end
    keep_next = en_reg && cs_reg && src_act;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wave_reg <= 4'h0;
      oe_reg <= 4'h0;
      keep_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
      oe_reg <= oe_next;
      keep_reg <= keep_next;
    end
  end

  assign wave_o = wave_reg;
  assign wave_oe_o = oe_reg;
  assign fast_osc_keep_o = keep_reg;
  assign hresp_o = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_enable_write;
    wr_con0 && regs.wdata[`CWU_EN_BIT] && !en_reg;
  endsequence
  sequence s_low_high;
    !data ##1 data;
  endsequence

  property p_enable_shut;
    @(posedge sys_clk_i) disable iff (sys_rst_i) s_enable_write |=> shut_reg && !ld_reg;
  endproperty
  a_enable_shut: assert property (p_enable_shut) else $error("enable did not shut down");

  property p_ld_ignored;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_enable_write and (!ld_reg ##0 1'b1)) |=> !ld_reg;
  endproperty
  a_ld_ignored: assert property (p_ld_ignored) else $error("load taken with enable");

  property p_auto_restart;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (shut_reg && ren_reg && en_reg && !fault && !regs.wr) |=> !shut_reg;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto restart failed");

  property p_hold_until_rise;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ($fell(shut_reg) && en_reg && !run_reg && !rise) |=> !run_reg;
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise) else $error("resumed early");

  property p_resume;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (en_reg && !shut_reg && !run_reg) ##0 s_low_high ##0 (en_reg && !shut_reg) |=> run_reg;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume on rising edge");

  property p_shut_level;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (shut_reg && second_pair_safe_level_reg == `CWU_LVL_HIGH) ##1 (second_pair_safe_level_reg == `CWU_LVL_HIGH)
      |=> wave_o[1] && wave_o[3];
  endproperty
  a_shut_level: assert property (p_shut_level) else $error("override level wrong");

  property p_steer;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (run_reg && mode_reg == CWU_ASYNC_STEER && !str_reg[0])
      |=> wave_o[0] == $past(str_reg[4]);
  endproperty
  a_steer: assert property (p_steer) else $error("forced level not driven");

  property p_osc_keep;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (en_reg && cs_reg && src_act) |=> fast_osc_keep_o;
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("oscillator not kept");
endmodule
`default_nettype wire

// ==== common/cwu_params.svh ====
// Register indexes, bit positions and fixed codes of the waveform unit.
`ifndef CWU_PARAMS_SVH
`define CWU_PARAMS_SVH
// Register indexes; the bus byte address is four times the index.
`define CWU_IDX_CLK 12'h50c
`define CWU_IDX_ISM 12'h50d
`define CWU_IDX_DBR 12'h50e
`define CWU_IDX_DBF 12'h50f
`define CWU_IDX_CON0 12'h510
`define CWU_IDX_CON1 12'h511
`define CWU_IDX_AS0 12'h512
`define CWU_IDX_AS1 12'h513
`define CWU_IDX_STR 12'h514
// Field positions.
`define CWU_EN_BIT 7
`define CWU_LD_BIT 6
`define CWU_IN_BIT 5
`define CWU_SHUT_BIT 7
`define CWU_REN_BIT 6
`define CWU_CS_BIT 0
// Reset and fixed values.
`define CWU_RST_BYTE 8'h00
`define CWU_RST_DB 6'h00
`define CWU_ISM_LAST 4'hb
`define CWU_LVL_HIGH 2'b11
`define CWU_LVL_LOW 2'b10
`define CWU_LVL_TRI 2'b01
`define CWU_HTRANS_NONSEQ 2'b10
`endif

// ==== common/cwu_pkg.sv ====
// Shared types of the waveform unit.
package cwu_pkg;
  typedef logic [31:0] cwu_word_t;
  typedef logic [11:0] cwu_idx_t;
  typedef enum logic [2:0] {
    CWU_ASYNC_STEER = 3'b000,
    CWU_SYNC_STEER = 3'b001,
    CWU_FWD_BRIDGE = 3'b010,
    CWU_REV_BRIDGE = 3'b011,
    CWU_HALF_BRIDGE = 3'b100,
    CWU_PUSH_PULL = 3'b101,
    CWU_RSVD_6 = 3'b110,
    CWU_RSVD_7 = 3'b111
  } cwu_mode_e;
endpackage

// ==== common/cwu_ifs.sv ====
// Interfaces between the core, its bus slave and its dead-band timers.
`timescale 1ns/10ps
`default_nettype none
interface cwu_reg_if;
  logic wr;
  logic [11:0] wr_idx;
  logic [7:0] wdata;
  logic [11:0] rd_idx;
  logic [7:0] rdata;
  modport slave(output wr, output wr_idx, output wdata, output rd_idx, input rdata);
  modport core(input wr, input wr_idx, input wdata, input rd_idx, output rdata);
endinterface

interface cwu_db_if;
  logic tick;
  logic din;
  logic [5:0] count;
  logic dout;
  modport gen(input tick, input din, input count, output dout);
  modport user(output tick, output din, output count, input dout);
endinterface
`default_nettype wire

// ==== logic/cwu_deadband.sv ====
// Dead-band timer: delays the rising edge of its input by a count of generator ticks.
`timescale 1ns/10ps
`default_nettype none
module cwu_deadband (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  cwu_db_if.gen db
);
  import cwu_pkg::*;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic out_reg;
  logic out_next;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // A fall of the input before the count ends cancels the pulse altogether.
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!db.din) begin
      cnt_next = 6'h00;
      out_next = 1'b0;
    end else if (db.count == 6'h00) begin
      out_next = 1'b1;
    end else if (!out_reg && db.tick) begin
      // The output rises on the tick after n ticks have passed, so a count of n adds n to n+1.
      if (cnt_reg == db.count) begin
        out_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 6'h00;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign db.dout = out_reg;

  property p_db_bypass;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (db.din && db.count == 6'h00) |=> db.dout;
  endproperty
  a_db_bypass: assert property (p_db_bypass) else $error("zero count did not bypass");

  property p_db_hold;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ($rose(db.din) && db.count != 6'h00 && db.tick) |=> !db.dout;
  endproperty
  a_db_hold: assert property (p_db_hold) else $error("dead band ended too early");
endmodule
`default_nettype wire

// ==== logic/cwu_ahb_slave.sv ====
// AHB-Lite slave front end of the waveform unit register file.
`timescale 1ns/10ps
`default_nettype none
`include "cwu_params.svh"
module cwu_ahb_slave (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire cwu_pkg::cwu_word_t haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire cwu_pkg::cwu_word_t hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  cwu_reg_if.slave regs
);
  import cwu_pkg::*;
  logic wr_ph_reg, wr_ph_next;
  logic rd_ph_reg, rd_ph_next;
  cwu_idx_t idx_reg, idx_next;
  logic rdy_reg, rdy_next;
  logic [7:0] rdat_reg, rdat_next;
  logic accept;

  // ----------------------------------------
  // Transfer tracking
  // ----------------------------------------
  // Reads take one wait state so that a write just before them is already stored.
  always_comb begin
    accept = hsel_i && htrans_i == `CWU_HTRANS_NONSEQ && hready_i;
    wr_ph_next = accept && hwrite_i;
    rd_ph_next = accept && !hwrite_i;
    idx_next = accept ? haddr_i[13:2] : idx_reg;
    rdy_next = !rd_ph_next;
    rdat_next = rd_ph_reg ? regs.rdata : rdat_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      idx_reg <= 12'h000;
      rdy_reg <= 1'b1;
      rdat_reg <= `CWU_RST_BYTE;
    end else begin
      wr_ph_reg <= wr_ph_next;
      rd_ph_reg <= rd_ph_next;
      idx_reg <= idx_next;
      rdy_reg <= rdy_next;
      rdat_reg <= rdat_next;
    end
  end

  assign regs.wr = wr_ph_reg;
  assign regs.wr_idx = idx_reg;
  assign regs.wdata = hwdata_i[7:0];
  assign regs.rd_idx = idx_reg;
  assign hrdata_o = {24'h000000, rdat_reg};
  assign hreadyout_o = rdy_reg;
endmodule
`default_nettype wire

// ==== testbench/cwu_stage_model.sv ====
// Model of the power stage that the four waveform outputs drive.
`timescale 1ns/10ps
`default_nettype none
module cwu_stage_model (
  input wire logic [3:0] drive_i,
  input wire logic [3:0] drive_oe_i,
  output logic [3:0] pin_o
);
  // A released gate input is held off by its pull-down, so a tri-stated output reads low.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_o[i] = drive_oe_i[i] ? drive_i[i] : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/complementary_waveform_ctrl_tb_top.sv ====
// Self-checking bench of the complementary waveform unit core.
`timescale 1ns/10ps
`default_nettype none
`include "cwu_params.svh"
module complementary_waveform_ctrl_tb_top;
  import cwu_pkg::*;
  logic clk = 0, rst = 1, hsel = 1, hwrite = 0, fosc = 0;
  logic [1:0] htrans = 0;
  cwu_word_t haddr = 0, hwdata = 0;
  logic [31:0] hrdata;
  logic hready, hresp, keep;
  logic [11:0] src = 0, act = 12'hfff;
  logic [7:0] flt_n = 8'hff, rv;
  logic [3:0] wave, oe, pins;
  int fail_count = 0, samples_checked = 0, d0, d;
  always #2.5 clk = ~clk;
  always @(posedge clk) fosc <= ~fosc;
  cwu_top u_cwu_top (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .data_src_i(src), .src_active_i(act), .fault_n_i(flt_n), .fast_osc_i(fosc),
    .wave_o(wave), .wave_oe_o(oe), .fast_osc_keep_o(keep));
  cwu_stage_model u_cwu_stage_model (.drive_i(wave), .drive_oe_i(oe), .pin_o(pins));
  // ----------------------------------------
  // Bus, data and comparison helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: bus never ready", $time);
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input cwu_idx_t idx, input logic [7:0] wd);
    @(posedge clk);
    htrans <= `CWU_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rv = hrdata[7:0];
  endtask
  task automatic wr(input cwu_idx_t idx, input logic [7:0] v);
    bus(1'b1, idx, v);
  endtask
  task automatic rdc(input cwu_idx_t idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(32'(rv), 32'(e));
  endtask
  // Six cycles cover the two-stage input sync plus the output register.
  task automatic dat(input logic v);
    @(posedge clk);
    src[0] <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic pc(input logic [3:0] e);
    check(32'(pins), 32'(e));
  endtask
  task automatic run_mode(input logic [2:0] m);
    wr(`CWU_IDX_CON0, {5'h00, m});
    wr(`CWU_IDX_CON0, {5'h10, m});
    wr(`CWU_IDX_AS0, 8'h38);
    dat(1'b0);
    dat(1'b1);
  endtask
  task automatic meas(output int n);
    @(posedge clk);
    src[0] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pins[0] !== 1'b1 && n < 100);
    if (pins[0] !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: output never rose", $time);
      stop_test();
    end
    dat(1'b0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(`CWU_IDX_CON0, 8'h00);
    rdc(`CWU_IDX_CON1, 8'h00);
    rdc(12'h7ff, 8'h00);
    check(32'(hresp), 32'h0);
  endtask
  task automatic t_start();
    wr(`CWU_IDX_CON0, 8'h00);
    wr(`CWU_IDX_CON1, 8'h00);
    wr(`CWU_IDX_ISM, 8'h00);
    wr(`CWU_IDX_STR, 8'h0f);
    wr(`CWU_IDX_AS0, 8'h38);
    wr(`CWU_IDX_AS1, 8'h00);
    wr(`CWU_IDX_DBR, 8'h00);
    wr(`CWU_IDX_DBF, 8'h00);
    wr(`CWU_IDX_CLK, 8'h00);
    wr(`CWU_IDX_CON0, 8'h80);
    repeat (4) @(posedge clk);
    pc(4'ha);
    rdc(`CWU_IDX_AS0, 8'hb8);
    wr(`CWU_IDX_AS0, 8'h38);
    repeat (6) @(posedge clk);
    pc(4'ha);
    dat(1'b1);
    pc(4'hf);
    dat(1'b0);
    pc(4'h0);
  endtask
  task automatic t_pol();
    wr(`CWU_IDX_CON1, 8'h05);
    repeat (6) @(posedge clk);
    pc(4'h5);
    rdc(`CWU_IDX_CON1, 8'h05);
    dat(1'b1);
    rdc(`CWU_IDX_CON1, 8'h25);
    pc(4'ha);
    wr(`CWU_IDX_STR, 8'h50);
    repeat (6) @(posedge clk);
    pc(4'h5);
    dat(1'b0);
    pc(4'h5);
    wr(`CWU_IDX_CON1, 8'h00);
    wr(`CWU_IDX_STR, 8'h0f);
  endtask
  task automatic t_shut();
    wr(`CWU_IDX_AS0, 8'hb8);
    repeat (4) @(posedge clk);
    pc(4'ha);
    dat(1'b1);
    pc(4'ha);
    rdc(`CWU_IDX_AS0, 8'hb8);
    wr(`CWU_IDX_AS0, 8'h98);
    repeat (4) @(posedge clk);
    check(32'(oe), 32'h5);
    pc(4'h0);
    wr(`CWU_IDX_AS0, 8'hf8);
    rdc(`CWU_IDX_AS0, 8'h78);
    pc(4'ha);
    dat(1'b0);
    dat(1'b1);
    pc(4'hf);
    dat(1'b0);
    wr(`CWU_IDX_AS0, 8'h38);
    wr(`CWU_IDX_AS1, 8'h01);
    flt_n <= 8'hfe;
    repeat (6) @(posedge clk);
    pc(4'ha);
    wr(`CWU_IDX_AS0, 8'h38);
    rdc(`CWU_IDX_AS0, 8'hb8);
    flt_n <= 8'hff;
    wr(`CWU_IDX_AS0, 8'h38);
    rdc(`CWU_IDX_AS0, 8'h38);
    wr(`CWU_IDX_AS1, 8'h00);
  endtask
  task automatic t_ism();
    for (int k = 0; k < 16; k++) begin
      wr(`CWU_IDX_ISM, 8'(k));
      src <= (k < 12) ? 12'h1 << k : 12'hfff;
      repeat (4) @(posedge clk);
      rdc(`CWU_IDX_CON1, (k < 12) ? 8'h20 : 8'h00);
      src <= ~(12'h1 << k);
      repeat (4) @(posedge clk);
      rdc(`CWU_IDX_CON1, 8'h00);
    end
    wr(`CWU_IDX_ISM, 8'h00);
    src <= 12'h000;
  endtask
  task automatic t_modes();
    logic [2:0] m [6] = '{3'd1, 3'd2, 3'd3, 3'd4, 3'd6, 3'd7};
    logic [3:0] hi [6] = '{4'hf, 4'h9, 4'h6, 4'h1, 4'h0, 4'h0};
    logic [3:0] lo [6] = '{4'h0, 4'h1, 4'h4, 4'h2, 4'h0, 4'h0};
    logic [3:0] mk [6] = '{4'hf, 4'hf, 4'hf, 4'h3, 4'hf, 4'hf};
    logic [1:0] a;
    for (int i = 0; i < 6; i++) begin
      run_mode(m[i]);
      check(32'(pins & mk[i]), 32'(hi[i]));
      dat(1'b0);
      check(32'(pins & mk[i]), 32'(lo[i]));
    end
    run_mode(3'd5);
    a = pins[1:0];
    check(32'(a[0] ^ a[1]), 32'h1);
    dat(1'b0);
    dat(1'b1);
    check(32'(pins[1:0]), 32'({a[0], a[1]}));
  endtask
  task automatic t_db();
    run_mode(3'd4);
    dat(1'b0);
    meas(d0);
    wr(`CWU_IDX_DBR, 8'h04);
    meas(d);
    check(d, d0);
    wr(`CWU_IDX_CON0, 8'hc4);
    rdc(`CWU_IDX_CON0, 8'hc4);
    dat(1'b1);
    dat(1'b0);
    meas(d);
    meas(d);
    check(32'((d - d0 >= 4) && (d - d0 <= 5)), 32'h1);
    rdc(`CWU_IDX_CON0, 8'h84);
    wr(`CWU_IDX_CON0, 8'h04);
    wr(`CWU_IDX_CON0, 8'hc4);
    rdc(`CWU_IDX_CON0, 8'h84);
  endtask
  task automatic t_clk();
    run_mode(3'd0);
    wr(`CWU_IDX_CLK, 8'h01);
    repeat (4) @(posedge clk);
    check(32'(keep), 32'h1);
    dat(1'b0);
    dat(1'b1);
    pc(4'hf);
    act[0] <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(keep), 32'h0);
    act[0] <= 1'b1;
    wr(`CWU_IDX_CON0, 8'h00);
    repeat (4) @(posedge clk);
    check(32'(keep), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_start();
    t_pol();
    t_shut();
    t_ism();
    t_modes();
    t_db();
    t_clk();
    stop_test();
  end
endmodule
`default_nettype wire
